//--- inc/cpf_pkg.sv
// constants, types and helpers of the calibration protocol framer
// assumes one 25 MHz clock; frame byte k sits in data[8*k +: 8]
//
// Contract
// - frames use standard 11-bit or extended 29-bit identifiers
// - every taken command gets a response within a bounded time
// - command path and acquisition path run independently
// - command and transmission objects each have their own identifier
// - packet id: 00..FC acquisition, FE event, FF response
// - responses and events are eight bytes: id, error code, data
// - response echoes the command counter unchanged
// - acquisition frame: id then at most seven data bytes
// - up to 253 acquisition messages, count is a parameter
// - each message has a table of address and size entries
// - entry data packs in table order into next free bytes
// - acquisition runs only after host start, timed or triggered
package cpf_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ         = 25;
  localparam int RSP_TIME_US     = 1000;
  localparam int RSP_TIMEOUT_CYC = RSP_TIME_US * CLK_MHZ;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [7:0] PID_EVENT    = 8'hFE;
  localparam logic [7:0] PID_RESPONSE = 8'hFF;
  localparam int         DAQ_MSG_MAX  = 253;
  localparam int         DAQ_DATA_MAX = 7;
  localparam logic [3:0] DLC_FULL     = 4'h8;
  localparam int         BYTE_CTR     = 2;
  localparam int         STD_ID_W     = 11;
  localparam int         EXT_ID_W     = 29;
  localparam int         ENT_ADDR_W   = 24;
  localparam int         ENT_SIZE_W   = 3;
  localparam int         ENT_W        = ENT_ADDR_W + ENT_SIZE_W;
  localparam int         ENT_IDX_W    = 3;
  localparam int         FIFO_DEPTH   = 16;
  localparam int         FIFO_W       = 68;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {TXK_DAQ, TXK_EVT, TXK_RSP} cpf_txk_t;

  // standard ids compare only the low 11 bits
  function automatic logic id_match(input logic [EXT_ID_W-1:0] id,
                                    input logic                ext,
                                    input logic [EXT_ID_W-1:0] cfg,
                                    input logic                cfg_ext);
    logic ok;
    ok = (ext == cfg_ext);
    if (ext)
      id_match = ok && (id == cfg);
    else
      id_match = ok && (id[STD_ID_W-1:0] == cfg[STD_ID_W-1:0]);
  endfunction

endpackage

//--- hw/cpf_odt_mem.sv
// object definition table store, one write and one registered read port
// assumes writes come from configuration logic on the same clock
`timescale 1ns/10ps
module cpf_odt_mem
  import cpf_pkg::*;
#(
  parameter int W = ENT_W,
  parameter int D = 8
)(
  // clock
  input  wire logic                 clock,
  // write port
  input  wire logic                 wr_en,
  input  wire logic [$clog2(D)-1:0] wr_addr,
  input  wire logic [W-1:0]         wr_data,
  // read port
  input  wire logic                 rd_en,
  input  wire logic [$clog2(D)-1:0] rd_addr,
  output logic      [W-1:0]         rd_data
);
  logic [W-1:0] mem [D];

  generate
    if (D < 2)
      $error("table depth too small");
  endgenerate

  // no reset on the array: tables are loaded before acquisition starts
  always_ff @(posedge clock)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (rd_en)
      rd_data <= mem[rd_addr];
  end
endmodule

//--- hw/cpf_fifo.sv
// synchronous fifo with valid and ready on both sides
// assumes both sides on the same clock
`timescale 1ns/10ps
module cpf_fifo
  import cpf_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_DEPTH
)(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  generate
    if (D < 2 || (1 << AW) != D)
      $error("fifo depth must be a power of two");
  endgenerate

  assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wp_d  = wp_q + AW'(push);
    rp_d  = rp_q + AW'(pop);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end
endmodule

//--- hw/cpf_framer.sv
// slave-side framer: command decode, response/event build, acquisition fill
// assumes can controller, application and memory all run on this clock
`timescale 1ns/10ps
module cpf_framer
  import cpf_pkg::*;
#(
  parameter int          NUM_MSG     = 4,
  parameter int          RSP_TIMEOUT = RSP_TIMEOUT_CYC,
  parameter logic [7:0]  OPEN_CODE   = 8'h01,
  parameter logic [7:0]  TIMEOUT_ERR = 8'h01
)(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // identifiers
  input  wire logic [EXT_ID_W-1:0]   cmd_id,
  input  wire logic                  cmd_ext,
  input  wire logic [EXT_ID_W-1:0]   tx_id_cfg,
  input  wire logic                  tx_ext_cfg,
  // received frames
  input  wire logic                  rx_valid,
  input  wire logic [EXT_ID_W-1:0]   rx_id,
  input  wire logic                  rx_ext,
  input  wire logic [3:0]            rx_dlc,
  input  wire logic [63:0]           rx_data,
  // transmitted frames
  output logic                       tx_valid_q,
  input  wire logic                  tx_ready,
  output logic      [EXT_ID_W-1:0]   tx_id_q,
  output logic                       tx_ext_q,
  output logic      [3:0]            tx_dlc_q,
  output logic      [63:0]           tx_data_q,
  // connection
  input  wire logic                  conn_open,
  input  wire logic                  conn_close,
  output logic                       connected_q,
  // commands to the application
  output logic                       cmd_valid_q,
  input  wire logic                  cmd_ready,
  output logic      [7:0]            cmd_code_q,
  output logic      [47:0]           cmd_param_q,
  input  wire logic                  rsp_valid,
  input  wire logic [7:0]            rsp_err,
  input  wire logic [39:0]           rsp_data,
  // events
  input  wire logic                  evt_valid,
  input  wire logic [7:0]            evt_err,
  input  wire logic [39:0]           evt_data,
  output logic                       evt_busy_q,
  // acquisition control and tables
  input  wire logic                  daq_enable,
  input  wire logic                  daq_trig,
  input  wire logic [15:0]           daq_period,
  input  wire logic                  odt_wr,
  input  wire logic [7:0]            odt_msg,
  input  wire logic [ENT_IDX_W-1:0]  odt_ent,
  input  wire logic [ENT_W-1:0]      odt_wdata,
  // memory read port
  output logic                       mem_req_q,
  output logic      [ENT_ADDR_W-1:0] mem_addr_q,
  input  wire logic                  mem_ack,
  input  wire logic [7:0]            mem_rdata
);
  localparam int MW = (NUM_MSG > 1) ? $clog2(NUM_MSG) : 1;
  localparam int TW = $clog2(RSP_TIMEOUT + 1);

  generate
    if (NUM_MSG < 1 || NUM_MSG > DAQ_MSG_MAX || RSP_TIMEOUT < 1)
      $error("unsupported message count or timeout");
  endgenerate

  // ****************************************
  // command path
  // ****************************************
  typedef enum logic [1:0] {C_IDLE, C_HAND, C_WAIT, C_SEND} cpf_cst_t;
  cpf_cst_t      cst_q, cst_d;
  logic [TW-1:0] tmo_q, tmo_d;
  logic [7:0]    ctr_q, ctr_d, err_q, err_d, code_d;
  logic [39:0]   rdat_q, rdat_d;
  logic [47:0]   par_d;
  logic          conn_d, cval_d, rx_hit, rsp_take;

  // only full frames on the command identifier count
  assign rx_hit = rx_valid && rx_dlc == DLC_FULL
                  && id_match(rx_id, rx_ext, cmd_id, cmd_ext);

  always_comb
  begin
    cst_d  = cst_q;
    tmo_d  = tmo_q;
    ctr_d  = ctr_q;
    err_d  = err_q;
    rdat_d = rdat_q;
    code_d = cmd_code_q;
    par_d  = cmd_param_q;
    cval_d = cmd_valid_q;
    // open wins over close so a late open is never lost
    conn_d = conn_open ? 1'b1 : (conn_close ? 1'b0 : connected_q);
    case (cst_q)
      C_IDLE:
        // commands before connection are dropped, except opening
        if (rx_hit && (connected_q || rx_data[7:0] == OPEN_CODE))
        begin
          code_d = rx_data[7:0];
          ctr_d  = rx_data[15:8];
          par_d  = rx_data[63:16];
          cval_d = 1'b1;
          tmo_d  = '0;
          cst_d  = C_HAND;
        end
      C_HAND:
      begin
        tmo_d = tmo_q + TW'(1);
        if (cmd_ready)
        begin
          cval_d = 1'b0;
          cst_d  = C_WAIT;
        end
        if (tmo_q == TW'(RSP_TIMEOUT - 1))
        begin
          cval_d = 1'b0;
          err_d  = TIMEOUT_ERR;
          rdat_d = '0;
          cst_d  = C_SEND;
        end
      end
      C_WAIT:
      begin
        tmo_d = tmo_q + TW'(1);
        if (rsp_valid)
        begin
          err_d  = rsp_err;
          rdat_d = rsp_data;
          cst_d  = C_SEND;
        end
        else if (tmo_q == TW'(RSP_TIMEOUT - 1))
        begin
          err_d  = TIMEOUT_ERR;
          rdat_d = '0;
          cst_d  = C_SEND;
        end
      end
      C_SEND:
        if (rsp_take)
          cst_d = C_IDLE;
      default:
        cst_d = C_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cst_q       <= C_IDLE;
      tmo_q       <= '0;
      ctr_q       <= '0;
      err_q       <= '0;
      rdat_q      <= '0;
      cmd_code_q  <= '0;
      cmd_param_q <= '0;
      cmd_valid_q <= 1'b0;
      connected_q <= 1'b0;
    end
    else
    begin
      cst_q       <= cst_d;
      tmo_q       <= tmo_d;
      ctr_q       <= ctr_d;
      err_q       <= err_d;
      rdat_q      <= rdat_d;
      cmd_code_q  <= code_d;
      cmd_param_q <= par_d;
      cmd_valid_q <= cval_d;
      connected_q <= conn_d;
    end
  end

  // ****************************************
  // acquisition fill
  // ****************************************
  typedef enum logic [2:0] {D_IDLE, D_ODT_RD, D_ODT_WAIT, D_FETCH, D_PUSH,
                            D_NEXT} cpf_dst_t;
  cpf_dst_t               dst_q, dst_d;
  logic [MW-1:0]          msg_q, msg_d;
  logic [ENT_IDX_W-1:0]   ent_q, ent_d;
  logic [2:0]             pos_q, pos_d, left_q, left_d;
  logic [63:0]            frm_q, frm_d;
  logic [ENT_ADDR_W-1:0]  addr_d;
  logic [15:0]            tmr_q, tmr_d;
  logic                   pend_q, pend_d, req_d, tick;
  logic                   odt_rd, f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [ENT_W-1:0]       ent_rd;
  logic [FIFO_W-1:0]      f_out;
  logic [3:0]             pos_ext;

  assign tick    = daq_enable && daq_period != '0 && tmr_q == daq_period - 16'h1;
  assign odt_rd  = (dst_q == D_ODT_RD);
  assign pos_ext = {1'b0, pos_q};

  always_comb
  begin
    dst_d      = dst_q;
    msg_d      = msg_q;
    ent_d      = ent_q;
    pos_d      = pos_q;
    left_d     = left_q;
    frm_d      = frm_q;
    addr_d     = mem_addr_q;
    f_in_valid = 1'b0;
    tmr_d      = (daq_enable && !tick) ? tmr_q + 16'h1 : '0;
    // trigger or timer tick sets pending; set wins over the clear at start, dropping enable clears it
    pend_d     = pend_q;
    case (dst_q)
      D_IDLE:
        if (pend_q && daq_enable)
        begin
          pend_d = 1'b0;
          msg_d  = '0;
          ent_d  = '0;
          pos_d  = '0;
          frm_d  = '0;
          dst_d  = D_ODT_RD;
        end
      D_ODT_RD:
        dst_d = D_ODT_WAIT;
      D_ODT_WAIT:
        // an entry that would pass seven bytes closes the frame
        if (ent_rd[ENT_SIZE_W-1:0] == '0 ||
            pos_ext + {1'b0, ent_rd[ENT_SIZE_W-1:0]} > 4'(DAQ_DATA_MAX))
          dst_d = D_PUSH;
        else
        begin
          addr_d = ent_rd[ENT_W-1:ENT_SIZE_W];
          left_d = ent_rd[ENT_SIZE_W-1:0];
          dst_d  = D_FETCH;
        end
      D_FETCH:
        if (mem_req_q && mem_ack)
        begin
          frm_d[8*(int'(pos_q)+1) +: 8] = mem_rdata;
          pos_d  = pos_q + 3'h1;
          addr_d = mem_addr_q + ENT_ADDR_W'(1);
          left_d = left_q - 3'h1;
          if (left_q == 3'h1)
          begin
            ent_d = ent_q + ENT_IDX_W'(1);
            dst_d = (ent_q == '1) ? D_PUSH : D_ODT_RD;
          end
        end
      D_PUSH:
        if (pos_q == '0)
          dst_d = D_NEXT;
        else
        begin
          f_in_valid = 1'b1;
          if (f_in_ready)
            dst_d = D_NEXT;
        end
      D_NEXT:
        if (msg_q == MW'(NUM_MSG - 1))
          dst_d = D_IDLE;
        else
        begin
          msg_d = msg_q + MW'(1);
          ent_d = '0;
          pos_d = '0;
          frm_d = '0;
          dst_d = D_ODT_RD;
        end
      default:
        dst_d = D_IDLE;
    endcase
    if (tick || (daq_trig && daq_enable))
      pend_d = 1'b1;
    if (!daq_enable)
      pend_d = 1'b0;
    req_d = (dst_d == D_FETCH) && !(mem_req_q && mem_ack);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dst_q      <= D_IDLE;
      msg_q      <= '0;
      ent_q      <= '0;
      pos_q      <= '0;
      left_q     <= '0;
      frm_q      <= '0;
      tmr_q      <= '0;
      pend_q     <= 1'b0;
      mem_req_q  <= 1'b0;
      mem_addr_q <= '0;
    end
    else
    begin
      dst_q      <= dst_d;
      msg_q      <= msg_d;
      ent_q      <= ent_d;
      pos_q      <= pos_d;
      left_q     <= left_d;
      frm_q      <= frm_d;
      tmr_q      <= tmr_d;
      pend_q     <= pend_d;
      mem_req_q  <= req_d;
      mem_addr_q <= addr_d;
    end
  end

  // one table of eight entries per message
  cpf_odt_mem #(.W(ENT_W), .D(NUM_MSG * 8)) u_odt (
    .clock   (clock),
    .wr_en   (odt_wr && odt_msg < 8'(NUM_MSG)),
    .wr_addr ($clog2(NUM_MSG*8)'({odt_msg, odt_ent})),
    .wr_data (odt_wdata),
    .rd_en   (odt_rd),
    .rd_addr ($clog2(NUM_MSG*8)'({msg_q, ent_q})),
    .rd_data (ent_rd)
  );

  // full fifo stalls the fill in D_PUSH; command traffic never waits here
  cpf_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   ({pos_ext + 4'h1, frm_q[63:8], 8'(msg_q)}),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out)
  );

  // ****************************************
  // transmit arbitration
  // ****************************************
  cpf_txk_t    kind_q, kind_d;
  logic        tval_d, ebusy_d, tfree;
  logic [3:0]  tdlc_d;
  logic [63:0] tdat_d;
  logic [7:0]  eerr_q, eerr_d;
  logic [39:0] edat_q, edat_d;

  assign tfree    = !tx_valid_q || tx_ready;
  // responses first, events next, acquisition frames fill the gaps
  assign rsp_take = tfree && cst_q == C_SEND;
  assign f_pop    = tfree && !rsp_take && !evt_busy_q && f_out_valid;

  always_comb
  begin
    tval_d  = tx_valid_q && !tx_ready;
    tdlc_d  = tx_dlc_q;
    tdat_d  = tx_data_q;
    kind_d  = kind_q;
    ebusy_d = evt_busy_q;
    eerr_d  = eerr_q;
    edat_d  = edat_q;
    if (evt_valid && !evt_busy_q)
    begin
      ebusy_d = 1'b1;
      eerr_d  = evt_err;
      edat_d  = evt_data;
    end
    if (rsp_take)
    begin
      tval_d = 1'b1;
      kind_d = TXK_RSP;
      tdlc_d = DLC_FULL;
      tdat_d = {rdat_q, ctr_q, err_q, PID_RESPONSE};
    end
    else if (tfree && evt_busy_q)
    begin
      tval_d  = 1'b1;
      kind_d  = TXK_EVT;
      ebusy_d = 1'b0;
      tdlc_d  = DLC_FULL;
      tdat_d  = {edat_q, 8'h00, eerr_q, PID_EVENT};
    end
    else if (f_pop)
    begin
      tval_d = 1'b1;
      kind_d = TXK_DAQ;
      tdlc_d = f_out[67:64];
      tdat_d = f_out[63:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_valid_q <= 1'b0;
      tx_dlc_q   <= '0;
      tx_data_q  <= '0;
      tx_id_q    <= '0;
      tx_ext_q   <= 1'b0;
      kind_q     <= TXK_DAQ;
      evt_busy_q <= 1'b0;
      eerr_q     <= '0;
      edat_q     <= '0;
    end
    else
    begin
      tx_valid_q <= tval_d;
      tx_dlc_q   <= tdlc_d;
      tx_data_q  <= tdat_d;
      tx_id_q    <= tx_id_cfg;
      tx_ext_q   <= tx_ext_cfg;
      kind_q     <= kind_d;
      evt_busy_q <= ebusy_d;
      eerr_q     <= eerr_d;
      edat_q     <= edat_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_RSP_FRAME: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(tx_valid_q) && kind_q == TXK_RSP |->
      tx_data_q[7:0] == PID_RESPONSE && tx_dlc_q == DLC_FULL)
    else $error("response frame malformed");
  AST_CTR_TAKE: assert property (@(posedge clock) disable iff (!arst_n)
    cst_q == C_IDLE && cst_d == C_HAND |=> ctr_q == $past(rx_data[15:8]))
    else $error("command counter not captured");
  AST_CTR_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    cst_q != C_IDLE |=> $stable(ctr_q))
    else $error("command counter changed before its response");
  AST_CTR_ECHO: assert property (@(posedge clock) disable iff (!arst_n)
    rsp_take |=> tx_valid_q && kind_q == TXK_RSP && tx_data_q[8*BYTE_CTR +: 8] == $past(ctr_q))
    else $error("response counter differs from command");
  AST_EVT_FRAME: assert property (@(posedge clock) disable iff (!arst_n)
    tx_valid_q && kind_q == TXK_EVT |->
      tx_data_q[7:0] == PID_EVENT && tx_dlc_q == DLC_FULL)
    else $error("event frame malformed");
  AST_DAQ_FRAME: assert property (@(posedge clock) disable iff (!arst_n)
    tx_valid_q && kind_q == TXK_DAQ |->
      tx_data_q[7:0] < 8'(NUM_MSG) && tx_dlc_q >= 4'h2 && tx_dlc_q <= DLC_FULL)
    else $error("acquisition frame malformed");
  AST_TIMEOUT: assert property (@(posedge clock) disable iff (!arst_n)
    (cst_q == C_HAND || cst_q == C_WAIT && !rsp_valid) && tmo_q == TW'(RSP_TIMEOUT - 1) |=>
      cst_q == C_SEND && err_q == TIMEOUT_ERR && !cmd_valid_q)
    else $error("missing timeout response");
  AST_CLOSED: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(cmd_valid_q) |-> $past(connected_q) || cmd_code_q == OPEN_CODE)
    else $error("command taken while not connected");
  AST_DAQ_HALT: assert property (@(posedge clock) disable iff (!arst_n)
    dst_q == D_IDLE && !daq_enable |=> dst_q == D_IDLE)
    else $error("acquisition started without enable");
  AST_PACK: assert property (@(posedge clock) disable iff (!arst_n)
    dst_q == D_FETCH && mem_req_q && mem_ack |=>
      pos_q == $past(pos_q) + 3'h1 && frm_q[8*int'(pos_q) +: 8] == $past(mem_rdata))
    else $error("data byte not packed in order");
  AST_TX_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q) && $stable(tx_dlc_q))
    else $error("transmit frame changed while stalled");
endmodule

//--- tb/cpf_host_model.sv
// host on the can side: sends command frames and takes transmitted frames
// assumes the framer samples on the rising edge; this model drives on the falling edge
`timescale 1ns/10ps
module cpf_host_model
  import cpf_pkg::*;
(
  // clock and pacing
  input  wire logic               clock,
  input  wire logic               slow,
  // command objects
  output logic                    rx_valid,
  output logic    [EXT_ID_W-1:0]  rx_id,
  output logic                    rx_ext,
  output logic    [3:0]           rx_dlc,
  output logic    [63:0]          rx_data,
  // transmission objects
  input  wire logic               tx_valid_q,
  output logic                    tx_ready,
  input  wire logic [3:0]         tx_dlc_q,
  input  wire logic [63:0]        tx_data_q
);
  logic [1:0]  pace = 2'h0;
  logic [3:0]  got_dlc;
  logic [63:0] got_data;
  int          got_cnt = 0;

  initial
  begin
    rx_valid = 1'b0;
    rx_id    = 29'h0000123;
    rx_ext   = 1'b0;
    rx_dlc   = 4'h8;
    rx_data  = 64'h0;
    tx_ready = 1'b0;
  end

  // data lines invert after a frame so stale bytes never look valid
  task automatic send(input logic [7:0] code, input logic [7:0] ctr, input logic [47:0] prm);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_data  = {prm, ctr, code};
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask

  // slow mode accepts only every fourth cycle, to stall the framer
  always @(negedge clock)
  begin
    pace     <= pace + 2'h1;
    tx_ready <= !slow || pace == 2'h3;
  end

  // the counter byte of an event is kept but never judged
  always @(posedge clock)
  begin
    if (tx_valid_q && tx_ready)
    begin
      got_dlc  <= tx_dlc_q;
      got_data <= tx_data_q;
      got_cnt  <= got_cnt + 1;
    end
  end
endmodule

//--- tb/calibration_protocol_framer_tb_top.sv
// self-checking bench of the framer: commands, timeout, event, acquisition
// assumes the host model on the can side; memory bytes come from mem_byte
`timescale 1ns/10ps
module calibration_protocol_framer_tb_top
  import cpf_pkg::*;
;
  localparam logic [7:0] TO_ERR = 8'hE7;
  logic        clock = 1'b0, arst_n = 1'b0, slow = 1'b0, conn_open = 1'b0;
  logic        conn_close = 1'b0, cmd_ready = 1'b0, rsp_valid = 1'b0, evt_valid = 1'b0;
  logic        daq_enable = 1'b0, daq_trig = 1'b0, odt_wr = 1'b0, mem_ack = 1'b0;
  logic [7:0]  rsp_err = 8'h0, evt_err = 8'h0, odt_msg = 8'h0, mem_rdata = 8'h0;
  logic [39:0] rsp_data = 40'h0, evt_data = 40'h0;
  logic [2:0]  odt_ent = 3'h0;
  logic [26:0] odt_wdata = 27'h0;
  logic        cmd_ext = 1'b0, tx_ext_cfg = 1'b1, tx_ext_q, evt_busy_q;
  logic [28:0] cmd_id = 29'h0000123, tx_id_cfg = 29'h1ABC0124, tx_id_q;
  logic [15:0] daq_period = 16'h0000;
  logic [28:0] rx_id;
  logic        rx_valid, rx_ext, tx_valid_q, tx_ready, connected_q, cmd_valid_q, mem_req_q;
  logic [3:0]  rx_dlc, tx_dlc_q;
  logic [63:0] rx_data, tx_data_q;
  logic [7:0]  cmd_code_q;
  logic [47:0] cmd_param_q;
  logic [23:0] mem_addr_q;
  int          num_errors = 0, compares = 0;
  wire  [63:0] got = i_cpf_host_model.got_data;
  wire  [3:0]  got_dlc = i_cpf_host_model.got_dlc;

  always #20 clock = ~clock;

  cpf_host_model i_cpf_host_model (.clock, .slow, .rx_valid, .rx_id, .rx_ext, .rx_dlc,
    .rx_data, .tx_valid_q, .tx_ready, .tx_dlc_q, .tx_data_q);

  cpf_framer #(.NUM_MSG(4), .RSP_TIMEOUT(20), .TIMEOUT_ERR(TO_ERR)) i_cpf_framer (
    .clock, .arst_n, .cmd_id, .cmd_ext, .tx_id_cfg,
    .tx_ext_cfg, .rx_valid, .rx_id, .rx_ext, .rx_dlc, .rx_data, .tx_valid_q,
    .tx_ready, .tx_id_q, .tx_ext_q, .tx_dlc_q, .tx_data_q, .conn_open, .conn_close,
    .connected_q, .cmd_valid_q, .cmd_ready, .cmd_code_q, .cmd_param_q, .rsp_valid,
    .rsp_err, .rsp_data, .evt_valid, .evt_err, .evt_data, .evt_busy_q, .daq_enable,
    .daq_trig, .daq_period, .odt_wr, .odt_msg, .odt_ent, .odt_wdata, .mem_req_q,
    .mem_addr_q, .mem_ack, .mem_rdata);

  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // memory answers each read one cycle after the request shows
  always @(negedge clock)
  begin
    mem_ack   <= mem_req_q && !mem_ack;
    mem_rdata <= mem_byte(mem_addr_q);
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask

  task automatic wait_frame(input int lim);
    int n0;
    n0 = i_cpf_host_model.got_cnt;
    repeat (lim) if (i_cpf_host_model.got_cnt == n0) @(negedge clock);
    chk(64'(i_cpf_host_model.got_cnt != n0), 64'h1);
  endtask

  task automatic cmd_rsp(input logic [7:0] ctr, input logic [7:0] err);
    i_cpf_host_model.send(8'h22, ctr, {6{ctr}});
    @(negedge clock);
    chk(cmd_valid_q, 1'b1);
    chk({cmd_param_q, cmd_code_q}, {{6{ctr}}, 8'h22});
    rsp_err  = err;
    rsp_data = {5{err ^ 8'h3C}};
    pulse(cmd_ready);
    pulse(rsp_valid);
    wait_frame(40);
    chk(got_dlc, DLC_FULL);
    chk(got, {rsp_data, ctr, err, PID_RESPONSE});
  endtask

  task automatic odt(input logic [7:0] m, input logic [2:0] e, input logic [23:0] a,
                     input logic [2:0] n);
    odt_msg   = m;
    odt_ent   = e;
    odt_wdata = {a, n};
    pulse(odt_wr);
  endtask

  task automatic expect_daq(input logic [7:0] idx, input logic [23:0] a0, input int n0,
                            input logic [23:0] a1, input int n1);
    logic [63:0] e;
    e = {56'h0, idx};
    for (int k = 0; k < n0 + n1; k++)
      e[8*k+8 +: 8] = mem_byte(k < n0 ? a0 + 24'(k) : a1 + 24'(k - n0));
    wait_frame(300);
    chk(got_dlc, 64'(n0 + n1 + 1));
    chk(got & (64'hFFFF_FFFF_FFFF_FFFF >> (56 - 8 * (n0 + n1))), e);
  endtask

  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    pulse(conn_open);
    chk(connected_q, 1'b1);
    chk({tx_ext_q, tx_id_q}, {1'b1, 29'h1ABC0124});
    slow = 1'b1;
    cmd_rsp(8'h00, 8'h00);
    cmd_rsp(8'hFF, 8'h35);
    slow = 1'b0;
    cmd_rsp(8'h5A, 8'hC3);
    i_cpf_host_model.send(8'h33, 8'h77, 48'h0);
    wait_frame(60);
    chk(got, {40'h0, 8'h77, TO_ERR, PID_RESPONSE});
    evt_err  = 8'h44;
    evt_data = 40'h0102030405;
    pulse(evt_valid);
    chk(evt_busy_q, 1'b1);
    wait_frame(10);
    chk(got & 64'hFFFF_FFFF_FF00_FFFF, {evt_data, 8'h00, evt_err, PID_EVENT});
    // message 1 stops at its second entry, which no longer fits
    odt(0, 0, 24'h000100, 2);
    odt(0, 1, 24'h000210, 3);
    odt(0, 2, 24'h0, 0);
    odt(1, 0, 24'h000300, 7);
    odt(1, 1, 24'h000400, 1);
    odt(2, 0, 24'h0, 0);
    odt(3, 0, 24'h0, 0);
    daq_enable = 1'b1;
    slow       = 1'b1;
    pulse(daq_trig);
    expect_daq(8'h00, 24'h000100, 2, 24'h000210, 3);
    expect_daq(8'h01, 24'h000300, 7, 24'h0, 0);
    // dropping enable clears the sample timer, so the first tick lands 64 cycles on
    daq_enable = 1'b0;
    @(negedge clock);
    daq_period = 16'h0040;
    daq_enable = 1'b1;
    expect_daq(8'h00, 24'h000100, 2, 24'h000210, 3);
    expect_daq(8'h01, 24'h000300, 7, 24'h0, 0);
    daq_enable = 1'b0;
    pulse(conn_close);
    chk(connected_q, 1'b0);
    i_cpf_host_model.send(8'h22, 8'h01, 48'h0);
    @(negedge clock);
    chk(cmd_valid_q, 1'b0);
    i_cpf_host_model.send(8'h01, 8'h02, 48'h0);
    chk(cmd_valid_q, 1'b1);
    test_done();
  end

  // the whole run needs well under 5000 cycles
  initial
  begin
    #2000000;
    num_errors++;
    test_done();
  end
endmodule
